// file: rtl/lpw_pkg.sv
// Summary of operation
// - Halt write keeps bit clock, input data low
// - Halt takes effect right after write decode
// - Halt frame carries only command slots
// - Controller drives sync, output data low after
// - Only controller wakes link: cold or warm
// - Registers kept through power-down, except resets
// - Any reset-register write restores register defaults
// - Sync stays low four frames after halt
// - Ready flag is input slot 0 bit 15
// - Cold reset holds reset line low minimum time
// - Reset line low restarts clock, defaults registers
// - Reset line acts asynchronously, needs no clock
// - Warm reset: sync high 1 us, no clock
// - Sync sampled in frames, asynchronously when halted
// - Clock restarts only after sync seen low again
// - Frame starts on sync rise, sampled falling
package lpw_pkg;
  // clock and link timing
  localparam int CLK_NS         = 4;
  localparam int HALF_CLKS      = 8;
  localparam int WARM_NS        = 1000;
  localparam int WARM_CLKS      = (WARM_NS + CLK_NS - 1) / CLK_NS;
  localparam int WARM_MARGIN    = 8;
  localparam int WARM_HOLD      = WARM_CLKS + WARM_MARGIN;
  localparam int COLD_NS        = 1000;
  localparam int COLD_CLKS      = (COLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_NS       = 20834;
  localparam int QUIET_FRAMES   = 4;
  localparam int QUIET_CLKS     = (QUIET_FRAMES * FRAME_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_NS       = 2000;
  localparam int READY_CLKS     = (READY_NS + CLK_NS - 1) / CLK_NS;
  // frame layout: slot 0 plus command slots 1 and 2
  localparam logic [7:0] SYNC_LEN = 8'h10;
  localparam logic [7:0] CMD_LEN  = 8'h38;
  localparam int W_VALID        = 55;
  localparam int W_TAG1         = 54;
  localparam int W_TAG2         = 53;
  localparam int W_RW           = 39;
  localparam int W_IDX_LO       = 32;
  localparam int W_DATA_LO      = 4;
  // device register indexes and defaults
  localparam logic [6:0]  IDX_RESET   = 7'h00;
  localparam logic [6:0]  IDX_VOLUME  = 7'h02;
  localparam logic [6:0]  IDX_PWR     = 7'h26;
  localparam int          LINK_HALT_BIT = 12;
  localparam logic [15:0] VOL_RST     = 16'h8000;
  localparam logic [7:0]  PR_RST      = 8'h00;
  localparam logic [15:0] ID_CODE     = 16'h0000;
  // controller register offsets and fields
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0C;
  localparam int CTRL_COLD = 0;
  localparam int CTRL_WARM = 1;
  localparam int CMD_READ  = 23;
  // state encodings
  typedef enum logic [1:0] {C_RUN, C_HALT, C_WAKE, C_WAIT_LOW} lpw_cmode_t;
  typedef enum logic [2:0] {H_RUN, H_QUIET, H_HALTED, H_WARM, H_COLD} lpw_hmode_t;
endpackage

// file: rtl/lpw_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// serial link between codec and controller
interface lpw_link_if;
  logic bit_clk;   // codec-made bit clock
  logic sdata_in;  // codec to controller data
  logic sync;      // frame sync and warm wake
  logic sdata_out; // controller to codec data
  logic reset_n;   // cold reset, active low
  modport codec (output bit_clk, output sdata_in, input sync, input sdata_out, input reset_n);
  modport ctrl (input bit_clk, input sdata_in, output sync, output sdata_out, output reset_n);
endinterface
`default_nettype wire

// file: rtl/lpw_sync2.sv
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser; first stage feeds only the second
module lpw_sync2 #(
  parameter int W = 1
) (
  // clock, reset, enable
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg; // metastable stage

  // both stages freeze with the clock enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else if (ce_in) begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: rtl/lpw_codec.sv
`timescale 1ns/100ps
`default_nettype none
// codec end: makes the bit clock, decodes commands, sleeps and wakes
module lpw_codec (
  // clock, reset, enable
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  input  wire logic  ce_in,
  // serial link
  lpw_link_if.codec  lnk,
  // state seen by the codec's own logic
  output logic       halted_out,
  output logic       ready_out,
  output logic [15:0] pwr_reg_out,
  output logic [15:0] vol_reg_out
);
  // all codec state
  typedef struct packed {
    lpw_pkg::lpw_cmode_t mode;     // link mode
    logic [2:0]          div;      // bit clock half-period divider
    logic                bclk;     // bit clock level
    logic                sdi;      // serial data toward controller
    logic                prev_sync;// sync at previous falling edge
    logic [7:0]          r;        // received bit index
    logic [54:0]         rx;       // received command bits
    logic [55:0]         tx;       // outgoing slot 0..2 shifter
    logic                ready;    // codec-ready flag
    logic [9:0]          rdy_cnt;  // settle time after restart
    logic [8:0]          warm_cnt; // sync-high time while halted
    logic [7:0]          pr;       // power-down control bits
    logic [15:0]         vol;      // volume register
    logic                rd_pend;  // read waits for next frame
    logic [6:0]          rd_idx;   // index to answer
  } lpw_cstate_t;

  lpw_cstate_t s_reg;  // registered state
  lpw_cstate_t s_next; // next state
  logic [1:0]  pin_s;  // synced {sync, sdata_out}
  logic        sync_s; // synced sync
  logic        sdo_s;  // synced controller data
  logic        hard_rst; // power-on or link cold reset
  logic [15:0] rdata;  // register read mux
  logic [55:0] w;      // completed command word
  logic [15:0] wdat;   // command write data
  logic [6:0]  widx;   // command index

  // link inputs come from another clock's world
  lpw_sync2 #(.W(2)) u_sync (
    .clk_in (clk_in),
    .rst_in (hard_rst),
    .ce_in  (ce_in),
    .d_in   ({lnk.sync, lnk.sdata_out}),
    .q_out  (pin_s)
  );
  assign sync_s = pin_s[1];
  assign sdo_s  = pin_s[0];

  // reset line works with no bit clock and no system edge
  assign hard_rst = rst_in | ~lnk.reset_n;

  // register read view
  always_comb begin
    unique case (s_reg.rd_idx)
      lpw_pkg::IDX_RESET:  rdata = lpw_pkg::ID_CODE;
      lpw_pkg::IDX_VOLUME: rdata = s_reg.vol;
      lpw_pkg::IDX_PWR:    rdata = {s_reg.pr, 4'h0, {4{s_reg.ready}}};
      default:             rdata = 16'h0000;
    endcase
  end

  // command word view once its last bit arrives
  assign w    = {s_reg.rx, sdo_s};
  assign wdat = w[lpw_pkg::W_DATA_LO +: 16];
  assign widx = w[lpw_pkg::W_IDX_LO +: 7];

  // next-state logic
  always_comb begin
    s_next = s_reg;
    if (ce_in) begin
      unique case (s_reg.mode)
        lpw_pkg::C_RUN: begin
          // settle count before claiming ready
          if (!s_reg.ready) begin
            if (s_reg.rdy_cnt == 10'(lpw_pkg::READY_CLKS - 1)) begin
              s_next.ready = 1'b1;
            end else begin
              s_next.rdy_cnt = s_reg.rdy_cnt + 10'h001;
            end
          end
          if (s_reg.div == 3'(lpw_pkg::HALF_CLKS - 1)) begin
            s_next.div  = 3'h0;
            s_next.bclk = ~s_reg.bclk;
            if (!s_reg.bclk) begin
              // rising edge: launch next outgoing bit
              s_next.sdi = s_reg.tx[55];
              s_next.tx  = {s_reg.tx[54:0], 1'b0};
            end else begin
              // falling edge: sync sampled here, in step with frames
              s_next.prev_sync = sync_s;
              if (sync_s && !s_reg.prev_sync) begin
                // new frame: load slot 0 to 2 for the controller
                s_next.r  = 8'h00;
                s_next.tx = {s_reg.ready, s_reg.rd_pend, s_reg.rd_pend, 13'h0000,
                             1'b0, s_reg.rd_idx, 12'h000, rdata, 4'h0};
                s_next.rd_pend = 1'b0;
              end else if (s_reg.r != lpw_pkg::CMD_LEN) begin
                s_next.rx = {s_reg.rx[53:0], sdo_s};
                s_next.r  = s_reg.r + 8'h01;
                if (s_reg.r == lpw_pkg::CMD_LEN - 8'h01 && w[lpw_pkg::W_VALID] && w[lpw_pkg::W_TAG1]) begin
                  if (w[lpw_pkg::W_RW]) begin
                    // read: answered in the next frame
                    s_next.rd_pend = 1'b1;
                    s_next.rd_idx  = widx;
                  end else if (w[lpw_pkg::W_TAG2]) begin
                    unique case (widx)
                      lpw_pkg::IDX_RESET: begin
                        // any value restores defaults
                        s_next.pr  = lpw_pkg::PR_RST;
                        s_next.vol = lpw_pkg::VOL_RST;
                      end
                      lpw_pkg::IDX_VOLUME: begin
                        s_next.vol = wdat;
                      end
                      lpw_pkg::IDX_PWR: begin
                        s_next.pr = wdat[15:8];
                        if (wdat[lpw_pkg::LINK_HALT_BIT]) begin
                          // halt at once, mid-frame, both lines low
                          s_next.mode = lpw_pkg::C_HALT;
                          s_next.bclk = 1'b0;
                          s_next.sdi  = 1'b0;
                          s_next.div  = 3'h0;
                        end
                      end
                      default: begin
                        // unimplemented index: write ignored
                        s_next.r = s_reg.r + 8'h01;
                      end
                    endcase
                  end
                end
              end
            end
          end else begin
            s_next.div = s_reg.div + 3'h1;
          end
        end
        lpw_pkg::C_HALT: begin
          // registers untouched while asleep
          s_next.bclk = 1'b0;
          s_next.sdi  = 1'b0;
          // no bit clock: sync watched as a plain level
          if (sync_s) begin
            s_next.mode     = lpw_pkg::C_WAKE;
            s_next.warm_cnt = 9'h000;
          end
        end
        lpw_pkg::C_WAKE: begin
          // a short pulse is not a warm reset
          if (!sync_s) begin
            s_next.mode = lpw_pkg::C_HALT;
          end else if (s_reg.warm_cnt == 9'(lpw_pkg::WARM_CLKS - 1)) begin
            s_next.mode = lpw_pkg::C_WAIT_LOW;
          end else begin
            s_next.warm_cnt = s_reg.warm_cnt + 9'h001;
          end
        end
        lpw_pkg::C_WAIT_LOW: begin
          // clock held off until sync falls, else that high
          // level would look like a frame start
          if (!sync_s) begin
            s_next.mode      = lpw_pkg::C_RUN;
            s_next.div       = 3'h0;
            s_next.bclk      = 1'b0;
            s_next.prev_sync = 1'b0;
            s_next.ready     = 1'b0;
            s_next.rdy_cnt   = 10'h000;
            s_next.r         = lpw_pkg::CMD_LEN;
            s_next.tx        = '0;
          end
        end
      endcase
    end
  end

  // state register; cold reset returns everything to defaults
  always_ff @(posedge clk_in or posedge hard_rst) begin
    if (hard_rst) begin
      s_reg <= '{mode: lpw_pkg::C_RUN, div: 3'h0, bclk: 1'b0, sdi: 1'b0, prev_sync: 1'b0,
                 r: lpw_pkg::CMD_LEN, rx: '0, tx: '0, ready: 1'b0, rdy_cnt: 10'h000,
                 warm_cnt: 9'h000, pr: lpw_pkg::PR_RST, vol: lpw_pkg::VOL_RST,
                 rd_pend: 1'b0, rd_idx: 7'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state
  assign lnk.bit_clk = s_reg.bclk;
  assign lnk.sdata_in = s_reg.sdi;
  assign halted_out  = (s_reg.mode != lpw_pkg::C_RUN);
  assign ready_out   = s_reg.ready;
  assign pwr_reg_out = {s_reg.pr, 4'h0, {4{s_reg.ready}}};
  assign vol_reg_out = s_reg.vol;
endmodule
`default_nettype wire

// file: rtl/lpw_ctrl.sv
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// controller end: frames commands, halts the link, wakes it
module lpw_ctrl #(
  parameter int QUIET = lpw_pkg::QUIET_CLKS // quiet time after halt
) (
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // serial link
  lpw_link_if.ctrl         lnk,
  // software register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out
);
  // all controller state
  typedef struct packed {
    lpw_pkg::lpw_hmode_t mode;      // link mode
    logic [7:0]          p;         // rising-edge count in frame
    logic                sync;      // sync drive
    logic                sdo;       // serial data drive
    logic                rst_n;     // reset line drive
    logic [15:0]         cnt;       // timed-phase counter
    logic                bclk_d;    // previous synced bit clock
    logic [54:0]         rx;        // incoming slot bits
    logic [55:0]         tx;        // outgoing slot shifter
    logic                ready;     // last codec-ready bit
    logic [22:0]         rdat;      // last read index and data
    logic                pend;      // command waiting
    logic [23:0]         pcmd;      // waiting command
    logic                halt_next; // halt after this frame's command slots
    logic                cold_req;  // cold wake asked
    logic                warm_req;  // warm wake asked
    logic [31:0]         rd_data;   // read data, one cycle late
  } lpw_hstate_t;

  lpw_hstate_t s_reg;  // registered state
  lpw_hstate_t s_next; // next state
  logic [1:0]  pin_s;  // synced {bit_clk, sdata_in}
  logic [7:0]  np;     // edge count after this rise
  logic [55:0] w;      // completed status word

  // bit clock and data arrive from the codec's timing
  lpw_sync2 #(.W(2)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .d_in   ({lnk.bit_clk, lnk.sdata_in}),
    .q_out  (pin_s)
  );

  assign np = s_reg.p + 8'h01;
  assign w  = {s_reg.rx, pin_s[0]};

  // next-state logic
  always_comb begin
    s_next = s_reg;
    if (ce_in) begin
      s_next.bclk_d = pin_s[1];
      unique case (s_reg.mode)
        lpw_pkg::H_RUN: begin
          if (pin_s[1] && !s_reg.bclk_d) begin
            // rise: sync high for slot 0, data one bit behind
            s_next.p    = np;
            s_next.sync = (np < lpw_pkg::SYNC_LEN);
            s_next.sdo  = s_reg.tx[55];
            s_next.tx   = {s_reg.tx[54:0], 1'b0};
            if (np == 8'h00) begin
              if (s_reg.halt_next) begin
                // halted: both driven lines parked low
                s_next.mode = lpw_pkg::H_QUIET;
                s_next.sync = 1'b0;
                s_next.sdo  = 1'b0;
                s_next.cnt  = 16'h0000;
                s_next.ready = 1'b0;
                s_next.halt_next = 1'b0;
              end else begin
                // only slots 0..2 ever carry data
                s_next.tx = {s_reg.pend, s_reg.pend, s_reg.pend & ~s_reg.pcmd[lpw_pkg::CMD_READ], 13'h0000,
                             s_reg.pcmd[23:16], 12'h000, s_reg.pcmd[15:0], 4'h0};
                s_next.halt_next = s_reg.pend & ~s_reg.pcmd[lpw_pkg::CMD_READ] &
                                   (s_reg.pcmd[22:16] == lpw_pkg::IDX_PWR) &
                                   s_reg.pcmd[lpw_pkg::LINK_HALT_BIT];
                s_next.pend = 1'b0;
              end
            end
          end else if (!pin_s[1] && s_reg.bclk_d && s_reg.p != 8'h00 && s_reg.p <= lpw_pkg::CMD_LEN) begin
            // fall: capture codec bit p-1
            s_next.rx = {s_reg.rx[53:0], pin_s[0]};
            if (s_reg.p == lpw_pkg::CMD_LEN) begin
              s_next.ready = w[lpw_pkg::W_VALID];
              if (w[lpw_pkg::W_TAG2]) begin
                s_next.rdat = {w[lpw_pkg::W_IDX_LO +: 7], w[lpw_pkg::W_DATA_LO +: 16]};
              end
              if (s_reg.halt_next) begin
                // codec stops its clock on this bit, so no frame end ever follows
                s_next.mode      = lpw_pkg::H_QUIET;
                s_next.sync      = 1'b0;
                s_next.sdo       = 1'b0;
                s_next.cnt       = 16'h0000;
                s_next.ready     = 1'b0;
                s_next.halt_next = 1'b0;
              end
            end
          end
        end
        lpw_pkg::H_QUIET: begin
          // sync may not rise for four frame times
          if (s_reg.cnt == 16'(QUIET - 1)) begin
            s_next.mode = lpw_pkg::H_HALTED;
          end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
          end
        end
        lpw_pkg::H_HALTED: begin
          if (s_reg.warm_req) begin
            s_next.mode = lpw_pkg::H_WARM;
            s_next.sync = 1'b1;
            s_next.cnt  = 16'h0000;
            s_next.warm_req = 1'b0;
          end
        end
        lpw_pkg::H_WARM: begin
          // held past 1 us plus synchroniser slack
          if (s_reg.cnt == 16'(lpw_pkg::WARM_HOLD - 1)) begin
            s_next.mode = lpw_pkg::H_RUN;
            s_next.sync = 1'b0;
            s_next.p    = 8'hFF;
          end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
          end
        end
        lpw_pkg::H_COLD: begin
          if (s_reg.cnt == 16'(lpw_pkg::COLD_CLKS - 1)) begin
            s_next.mode  = lpw_pkg::H_RUN;
            s_next.rst_n = 1'b1;
            s_next.p     = 8'hFF;
          end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
          end
        end
      endcase
      // cold wake overrides any mode but H_COLD
      if (s_reg.cold_req && s_reg.mode != lpw_pkg::H_COLD) begin
        s_next.mode = lpw_pkg::H_COLD;
        s_next.rst_n = 1'b0;
        s_next.sync = 1'b0;
        s_next.sdo = 1'b0;
        s_next.cnt = 16'h0000;
        s_next.cold_req = 1'b0;
        s_next.warm_req = 1'b0;
        s_next.halt_next = 1'b0;
        s_next.tx = '0;
        s_next.ready = 1'b0;
      end
      // writes last, so a new request beats its own clearing
      if (wr_in && addr_in == lpw_pkg::OFS_CTRL) begin
        if (wdata_in[lpw_pkg::CTRL_COLD]) s_next.cold_req = 1'b1;
        if (wdata_in[lpw_pkg::CTRL_WARM]) s_next.warm_req = 1'b1;
      end
      if (wr_in && addr_in == lpw_pkg::OFS_CMD && !s_next.pend) begin
        s_next.pend = 1'b1;
        s_next.pcmd = wdata_in[23:0];
      end
      // read data for the following cycle
      s_next.rd_data = 32'h0000_0000;
      if (rd_in) begin
        unique case (addr_in)
          lpw_pkg::OFS_STATUS: s_next.rd_data = {26'h0, s_reg.warm_req, s_reg.cold_req, s_reg.pend,
                                                 s_reg.mode == lpw_pkg::H_QUIET,
                                                 s_reg.mode == lpw_pkg::H_HALTED, s_reg.ready};
          lpw_pkg::OFS_RDATA:  s_next.rd_data = {9'h000, s_reg.rdat};
          lpw_pkg::OFS_CMD:    s_next.rd_data = {8'h00, s_reg.pcmd};
          default:             s_next.rd_data = 32'h0000_0000;
        endcase
      end
    end
  end

  // state register; reset line low while this end resets
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '{mode: lpw_pkg::H_COLD, p: 8'hFF, sync: 1'b0, sdo: 1'b0, rst_n: 1'b0,
                 cnt: 16'h0000, bclk_d: 1'b0, rx: '0, tx: '0, ready: 1'b0, rdat: '0,
                 pend: 1'b0, pcmd: '0, halt_next: 1'b0, cold_req: 1'b0, warm_req: 1'b0,
                 rd_data: 32'h0000_0000};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs from state
  assign lnk.sync      = s_reg.sync;
  assign lnk.sdata_out = s_reg.sdo;
  assign lnk.reset_n   = s_reg.rst_n;
  assign rdata_out     = s_reg.rd_data;
endmodule
`default_nettype wire

// file: verification/lpw_chk.sv
`timescale 1ns/100ps
`default_nettype none
// link watcher; counters saturate so a long halt never wraps them
module lpw_chk #(
  parameter int QUIET = lpw_pkg::QUIET_CLKS // quiet time after halt
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // link wires
  input wire logic bit_clk,
  input wire logic sdata_in,
  input wire logic sync,
  input wire logic sdata_out,
  input wire logic reset_n
);
  logic [15:0] idle_cnt; // clocks since bit clock was high
  logic [15:0] warm_cnt; // sync high clocks while halted
  logic [15:0] low_cnt;  // reset line low clocks
  logic        woke_q;   // wake seen since clock last ran
  logic        idle;     // clock stopped, not just a low phase
  assign idle = idle_cnt >= 16'h0020;
  // helper counters
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_cnt <= 16'h0000;
      warm_cnt <= 16'h0000;
      low_cnt  <= 16'h0000;
      woke_q   <= 1'b0;
    end else begin
      idle_cnt <= bit_clk ? 16'h0000 : idle_cnt + 16'(~&idle_cnt);
      warm_cnt <= bit_clk ? 16'h0000 : warm_cnt + 16'(idle && sync && ~&warm_cnt);
      low_cnt  <= reset_n ? 16'h0000 : low_cnt + 16'(~&low_cnt);
      woke_q   <= !bit_clk && (woke_q || sync || !reset_n);
    end
  end
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  halt_hold_a: assert property (idle && !woke_q && !sync && reset_n |=> !bit_clk && !sdata_in)
    else $error("link woke alone");
  park_low_a: assert property (idle_cnt >= 16'h0040 |-> !sdata_out) else $error("data not parked");
  quiet_gap_a: assert property (idle && $rose(sync) |-> idle_cnt >= 16'(QUIET)) else $error("sync early");
  cold_len_a: assert property ($rose(reset_n) |-> low_cnt >= 16'(lpw_pkg::COLD_CLKS - 1))
    else $error("cold too short");
  cold_run_a: assert property ($rose(reset_n) |-> ##[1:40] bit_clk) else $error("no clock");
  reset_low_a: assert property (!reset_n |-> !bit_clk && !sdata_in) else $error("reset ignored");
  warm_len_a: assert property (idle && $fell(sync) |-> warm_cnt >= 16'(lpw_pkg::WARM_CLKS))
    else $error("warm too short");
  warm_run_a: assert property (idle && $fell(sync) |-> ##[1:48] bit_clk) else $error("no warm clock");
  warm_wait_a: assert property (idle && sync |=> !bit_clk) else $error("clock under sync");
  frame_edge_a: assert property (!idle && $rose(sync) |-> bit_clk) else $error("sync off edge");
endmodule
`default_nettype wire

// file: verification/link_powerdown_wake_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// both ends back to back, driven through the controller's register port
module link_powerdown_wake_tb_top;
  localparam int QUIET = 50; // short quiet keeps the run brief
  logic        clk_in;
  logic        rst_in;
  logic        ce_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic        halted_out;
  logic        ready_out;
  logic [15:0] pwr_reg_out;
  logic [15:0] vol_reg_out;
  logic [63:0] note_q[$]; // mask and expected read data
  logic [63:0] note;
  logic        rd_d;      // read answer due now
  logic [31:0] v;         // last read data
  logic [15:0] vol;       // volume last written
  int          miscompares;
  int          checks;
  lpw_link_if u_lpw_link_if();
  lpw_codec u_lpw_codec (.clk_in, .rst_in, .ce_in, .lnk(u_lpw_link_if), .halted_out, .ready_out, .pwr_reg_out,
    .vol_reg_out);
  lpw_ctrl #(.QUIET(QUIET)) u_lpw_ctrl (.clk_in, .rst_in, .ce_in, .lnk(u_lpw_link_if), .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out);
  lpw_chk #(.QUIET(QUIET)) u_lpw_chk (.clk_in, .rst_in, .bit_clk(u_lpw_link_if.bit_clk),
    .sdata_in(u_lpw_link_if.sdata_in), .sync(u_lpw_link_if.sync), .sdata_out(u_lpw_link_if.sdata_out),
    .reset_n(u_lpw_link_if.reset_n));
  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // one-cycle read; the monitor judges the masked answer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    note_q.push_back({m, e});
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    v = rdata_out;
  endtask
  // answer stands only the cycle after the strobe
  always @(posedge clk_in) begin
    rd_d <= rd_in;
    if (rd_d === 1'b1 && note_q.size() > 0) begin
      note = note_q.pop_front();
      chk(rdata_out & note[63:32], note[31:0]);
    end
  end
  // bounded wait; running out counts as a mismatch
  task automatic wait_on(input int sel, input logic lvl);
    for (int k = 0; k < 12000; k++) begin
      if ((sel == 0 ? ready_out : sel == 1 ? halted_out : vol_reg_out === vol) === lvl) return;
      @(posedge clk_in);
    end
    miscompares++;
    $display("ERROR %0t: wait timed out", $time);
  endtask
  // codec register write through a command frame
  task automatic cmd(input logic [6:0] idx, input logic [15:0] d);
    wr(lpw_pkg::OFS_CMD, {9'h000, idx, d});
  endtask
  // halt the link and see both codec wires drop
  task automatic halt_link;
    cmd(lpw_pkg::IDX_PWR, 16'h0001 << lpw_pkg::LINK_HALT_BIT);
    wait_on(1, 1'b1);
    chk({30'h0, u_lpw_link_if.bit_clk, u_lpw_link_if.sdata_in}, 32'h0);
    // controller sees the stopped clock through its synchroniser first
    repeat (4) @(posedge clk_in);
    rd(lpw_pkg::OFS_STATUS, 32'h4, 32'h7);
    repeat (QUIET) @(posedge clk_in);
    rd(lpw_pkg::OFS_STATUS, 32'h2, 32'h7);
  endtask
  // wake, then wait for readiness; ready must start clear
  task automatic wake(input logic [31:0] how);
    wr(lpw_pkg::OFS_CTRL, how);
    wait_on(1, 1'b0);
    chk({31'h0, ready_out}, 32'h0);
    wait_on(0, 1'b1);
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    addr_in = 8'h00;
    wdata_in = 32'h00000000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    miscompares = 0;
    checks = 0;
    vol = {1'b0, 15'($urandom(32'hA70B))};
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    chk({8'h00, pwr_reg_out[15:8], vol_reg_out}, {8'h00, lpw_pkg::PR_RST, lpw_pkg::VOL_RST});
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    repeat (300) @(posedge clk_in);
    chk({31'h0, ready_out}, 32'h0);
    wait_on(0, 1'b1);
    // the flag reaches the controller only in a later frame's slot 0
    repeat (2 * 512 * lpw_pkg::HALF_CLKS) @(posedge clk_in);
    rd(lpw_pkg::OFS_STATUS, 32'h1, 32'h3);
    $display("test power_up done");
    cmd(lpw_pkg::IDX_VOLUME, vol);
    wait_on(2, 1'b1);
    chk({16'h0, vol_reg_out}, {16'h0, vol});
    wr(lpw_pkg::OFS_CMD, {8'h00, 1'b1, lpw_pkg::IDX_VOLUME, 16'h0000});
    v = 32'h0;
    for (int i = 0; i < 40 && v[22:16] !== lpw_pkg::IDX_VOLUME; i++) begin
      repeat (256) @(posedge clk_in);
      rd(lpw_pkg::OFS_RDATA, 32'h0, 32'h0);
    end
    rd(lpw_pkg::OFS_RDATA, {9'h000, lpw_pkg::IDX_VOLUME, vol}, 32'h007FFFFF);
    $display("test frames done");
    halt_link();
    wake(32'h2);
    chk({16'h0, vol_reg_out}, {16'h0, vol});
    $display("test warm done");
    halt_link();
    wake(32'h1);
    chk({16'h0, vol_reg_out}, {16'h0, lpw_pkg::VOL_RST});
    $display("test cold done");
    vol = {1'b0, 15'($urandom())};
    cmd(lpw_pkg::IDX_VOLUME, vol);
    wait_on(2, 1'b1);
    cmd(lpw_pkg::IDX_RESET, 16'($urandom()));
    vol = lpw_pkg::VOL_RST;
    wait_on(2, 1'b1);
    chk({16'h0, vol_reg_out}, {16'h0, lpw_pkg::VOL_RST});
    $display("test register_reset done");
    wrap_up();
  end
  // watchdog
  initial begin
    #(90000 * lpw_pkg::CLK_NS);
    miscompares++;
    $display("ERROR %0t: run timed out", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
